/* design/duc_pkg.sv */
package duc_pkg;

	localparam int CHANNELS = 16;
	localparam int CODE_W   = 12;

	// register indices as printed; byte address is four times the index
	localparam logic [3:0] IDX_CHAN_DATA  = 4'h0;
	localparam logic [3:0] IDX_TRIGGER    = 4'h5;
	localparam logic [3:0] IDX_BCAST_CODE = 4'h6;
	localparam logic [3:0] IDX_SETTINGS   = 4'h9;
	localparam logic [3:0] IDX_SYNC_EN    = 4'hA;
	localparam logic [3:0] IDX_BROADCAST_ACCEPT_ENABLE   = 4'hB;
	localparam logic [3:0] IDX_BCAST_CLR  = 4'hE;
	localparam logic [3:0] IDX_PIN_DATA   = 4'h1;
	localparam logic [3:0] IDX_ACTIVE_RD  = 4'h2;

	localparam logic [15:0] SYNC_EN_RST  = 16'h0000;
	localparam logic [15:0] BROADCAST_ACCEPT_ENABLE_RST = 16'hFFFF;

	localparam int SETTINGS_FUNC_BIT = 0;
	localparam int CODE_LSB          = 4;
	localparam int TRIG_PAIR_LSB     = 8;
	localparam int CHAN_SEL_LSB      = 16;

	typedef struct packed {
		logic        write;
		logic [3:0]  index;
		logic [31:0] wdata;
	} duc_req_t;

	typedef struct packed {
		logic [11:0] buffer;
		logic [11:0] active;
		logic [11:0] clear_code;
	} duc_chan_t;

endpackage : duc_pkg

/* design/duc_channel.sv */
`timescale 1ns/10ps
module duc_channel #(
	parameter int CODE_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              sync_en,
	input  wire logic              broadcast_accept_enable,
	input  wire logic              direct_wr,
	input  wire logic              bcast_wr,
	input  wire logic              bcast_clr_wr,
	input  wire logic              trigger,
	input  wire logic [CODE_W-1:0] wr_code,
	output duc_pkg::duc_chan_t     state
);

	duc_pkg::duc_chan_t st_q;
	duc_pkg::duc_chan_t st_d;

	always_comb
	begin
		st_d = st_q;
		if (direct_wr)
		begin
			st_d.buffer = wr_code;
			if (!sync_en)
				st_d.active = wr_code;
		end
		// synchronous channels keep active on plain buffer writes
		if (trigger && sync_en)
			st_d.active = st_q.buffer;
		if (bcast_wr && broadcast_accept_enable)
		begin
			st_d.buffer = wr_code;
			st_d.active = wr_code;
		end
		if (bcast_clr_wr && broadcast_accept_enable)
			st_d.clear_code = wr_code;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign state = st_q;

endmodule : duc_channel

/* design/duc_update_ctrl.sv */
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
module duc_update_ctrl #(
	parameter int CHANNELS = 16,
	parameter int CODE_W   = 12
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                load_strobe_pin_n,
	input  wire logic                multi_function_pin_in,
	output logic                     multi_function_pin_out,
	output logic                     multi_function_pin_oe,
	output logic [CHANNELS-1:0]      channel_clear,
	output logic [CHANNELS*CODE_W-1:0] active_codes
);

	typedef enum logic [0:0] {DUC_IDLE, DUC_ACK} duc_state_t;

	function automatic logic duc_known(input logic [3:0] idx);
		duc_known = (idx == duc_pkg::IDX_CHAN_DATA) || (idx == duc_pkg::IDX_TRIGGER)
			|| (idx == duc_pkg::IDX_BCAST_CODE) || (idx == duc_pkg::IDX_SETTINGS)
			|| (idx == duc_pkg::IDX_SYNC_EN) || (idx == duc_pkg::IDX_BROADCAST_ACCEPT_ENABLE)
			|| (idx == duc_pkg::IDX_BCAST_CLR) || (idx == duc_pkg::IDX_PIN_DATA)
			|| (idx == duc_pkg::IDX_ACTIVE_RD);
	endfunction : duc_known

	duc_state_t          st_q;
	duc_state_t          st_d;
	logic [15:0]         sync_en_q;
	logic [15:0]         sync_en_d;
	logic [15:0]         broadcast_accept_enable_q;
	logic [15:0]         broadcast_accept_enable_d;
	logic                func_q;
	logic                func_d;
	logic                pin_data_q;
	logic                pin_data_d;
	logic [3:0]          chan_sel_q;
	logic [3:0]          chan_sel_d;
	logic [CODE_W-1:0]   bcode_q;
	logic [CODE_W-1:0]   bcode_d;
	logic [CODE_W-1:0]   bclr_q;
	logic [CODE_W-1:0]   bclr_d;
	logic [7:0]          trig_q;
	logic [7:0]          trig_d;
	logic [31:0]         prdata_d;
	logic                pslverr_d;
	logic                pin_out_d;
	logic                pin_oe_d;
	logic [CHANNELS-1:0] clear_d;
	logic                strobe_q;
	logic                strobe_fall;
	logic                wr_take;
	duc_pkg::duc_req_t   req;
	logic [CODE_W-1:0]   wr_code;
	duc_pkg::duc_chan_t  chan_st [CHANNELS];
	logic [CHANNELS*CODE_W-1:0] act_d;

	assign req.write = pwrite;
	assign req.index = paddr[5:2];
	assign req.wdata = pwdata;
	assign wr_code   = req.wdata[duc_pkg::CODE_LSB +: CODE_W];
	// writes take effect in the setup cycle; access completes one cycle later
	assign wr_take     = psel && !penable && req.write && (st_q == DUC_IDLE)
		&& duc_known(req.index);
	assign strobe_fall = strobe_q && !load_strobe_pin_n;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			DUC_IDLE:
				if (psel && !penable)
					st_d = DUC_ACK;
			DUC_ACK:
				st_d = DUC_IDLE;
			default:
				st_d = DUC_IDLE;
		endcase
	end

	always_comb
	begin
		sync_en_d  = sync_en_q;
		broadcast_accept_enable_d = broadcast_accept_enable_q;
		func_d     = func_q;
		pin_data_d = pin_data_q;
		chan_sel_d = chan_sel_q;
		bcode_d    = bcode_q;
		bclr_d     = bclr_q;
		trig_d     = '0;
		prdata_d   = prdata;
		pslverr_d  = 1'b0;
		if (psel && !penable && st_q == DUC_IDLE)
		begin
			pslverr_d = !duc_known(req.index);
			prdata_d  = 32'h0000_0000;
			if (!req.write)
				case (req.index)
					duc_pkg::IDX_SETTINGS:   prdata_d[0] = func_q;
					duc_pkg::IDX_SYNC_EN:    prdata_d[15:0] = sync_en_q;
					duc_pkg::IDX_BROADCAST_ACCEPT_ENABLE:   prdata_d[15:0] = broadcast_accept_enable_q;
					duc_pkg::IDX_BCAST_CODE:
						prdata_d[duc_pkg::CODE_LSB +: CODE_W] = bcode_q;
					duc_pkg::IDX_BCAST_CLR:
						prdata_d[duc_pkg::CODE_LSB +: CODE_W] = bclr_q;
					duc_pkg::IDX_PIN_DATA:   prdata_d[0] = pin_data_q;
					duc_pkg::IDX_ACTIVE_RD:
						prdata_d[duc_pkg::CODE_LSB +: CODE_W] = chan_st[chan_sel_q].active;
					duc_pkg::IDX_CHAN_DATA:
					begin
						prdata_d[duc_pkg::CODE_LSB +: CODE_W] = chan_st[chan_sel_q].buffer;
						prdata_d[duc_pkg::CHAN_SEL_LSB +: 4]  = chan_sel_q;
					end
					default:                 prdata_d = 32'h0000_0000;
				endcase
		end
		if (wr_take)
			case (req.index)
				duc_pkg::IDX_SETTINGS:
					func_d = req.wdata[duc_pkg::SETTINGS_FUNC_BIT];
				duc_pkg::IDX_SYNC_EN:    sync_en_d  = req.wdata[15:0];
				duc_pkg::IDX_BROADCAST_ACCEPT_ENABLE:   broadcast_accept_enable_d = req.wdata[15:0];
				duc_pkg::IDX_BCAST_CODE: bcode_d = wr_code;
				duc_pkg::IDX_BCAST_CLR:  bclr_d  = wr_code;
				duc_pkg::IDX_PIN_DATA:   pin_data_d = req.wdata[0];
				duc_pkg::IDX_TRIGGER:
					trig_d = req.wdata[duc_pkg::TRIG_PAIR_LSB +: 8];
				duc_pkg::IDX_CHAN_DATA:
					chan_sel_d = req.wdata[duc_pkg::CHAN_SEL_LSB +: 4];
				default:                 pslverr_d = 1'b0;
			endcase
	end

	always_comb
	begin
		// clear pin is ignored while the pin serves as a plain output
		pin_out_d = 1'b0;
		pin_oe_d  = 1'b0;
		if (!func_q)
		begin
			pin_oe_d = !pin_data_q;
		end
		for (int i = 0; i < CHANNELS; i++)
			clear_d[i] = func_q && !multi_function_pin_in;
	end

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_chan
			duc_channel #(
				.CODE_W (CODE_W)
			) u_chan (
				.pclk         (pclk),
				.presetn      (presetn),
				.sync_en      (sync_en_q[g]),
				.broadcast_accept_enable     (broadcast_accept_enable_q[g]),
				.direct_wr    (wr_take && req.index == duc_pkg::IDX_CHAN_DATA
					&& req.wdata[duc_pkg::CHAN_SEL_LSB +: 4] == g),
				.bcast_wr     (wr_take && req.index == duc_pkg::IDX_BCAST_CODE),
				.bcast_clr_wr (wr_take && req.index == duc_pkg::IDX_BCAST_CLR),
				.trigger      (trig_q[g/2] || strobe_fall),
				.wr_code      (wr_code),
				.state        (chan_st[g])
			);
			assign act_d[g*CODE_W +: CODE_W] = chan_st[g].active;
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q                   <= DUC_IDLE;
			sync_en_q              <= duc_pkg::SYNC_EN_RST;
			broadcast_accept_enable_q             <= duc_pkg::BROADCAST_ACCEPT_ENABLE_RST;
			func_q                 <= 1'b0;
			pin_data_q             <= 1'b0;
			chan_sel_q             <= 4'h0;
			bcode_q                <= 12'h000;
			bclr_q                 <= 12'h000;
			trig_q                 <= 8'h00;
			prdata                 <= 32'h0000_0000;
			pslverr                <= 1'b0;
			pready                 <= 1'b0;
			multi_function_pin_out <= 1'b0;
			multi_function_pin_oe  <= 1'b0;
			channel_clear          <= '0;
			active_codes           <= '0;
			strobe_q               <= 1'b1;
		end
		else
		begin
			st_q                   <= st_d;
			sync_en_q              <= sync_en_d;
			broadcast_accept_enable_q             <= broadcast_accept_enable_d;
			func_q                 <= func_d;
			pin_data_q             <= pin_data_d;
			chan_sel_q             <= chan_sel_d;
			bcode_q                <= bcode_d;
			bclr_q                 <= bclr_d;
			trig_q                 <= trig_d;
			prdata                 <= prdata_d;
			pslverr                <= pslverr_d;
			pready                 <= (st_d == DUC_ACK);
			multi_function_pin_out <= pin_out_d;
			multi_function_pin_oe  <= pin_oe_d;
			channel_clear          <= clear_d;
			active_codes           <= act_d;
			strobe_q               <= load_strobe_pin_n;
		end
	end

endmodule : duc_update_ctrl

/* tb/duc_update_ctrl_asserts.sv */
`timescale 1ns/10ps
module duc_update_ctrl_asserts #(
	parameter int CHANNELS = 16,
	parameter int CODE_W   = 12
) (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [31:0]                  prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire logic                         load_strobe_pin_n,
	input wire logic                         multi_function_pin_in,
	input wire logic                         multi_function_pin_out,
	input wire logic                         multi_function_pin_oe,
	input wire logic [CHANNELS-1:0]          channel_clear,
	input wire logic [CHANNELS*CODE_W-1:0]   active_codes
);
	logic [2:0] quiet_q;
	logic [2:0] quiet_d;
	// saturating count of cycles since the last write or strobe low
	always_comb
		quiet_d = ((psel && !penable && pwrite) || !load_strobe_pin_n) ? 3'h0 :
			((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			quiet_q <= 3'h7;
		else
			quiet_q <= quiet_d;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_pin_sinks_only: assert property (multi_function_pin_out == 1'b0)
		else $error("pin driven high");
	a_clear_needs_low: assert property (|channel_clear |-> $past(!multi_function_pin_in))
		else $error("clear without low pin");
	a_clear_no_drive: assert property (|channel_clear |-> !multi_function_pin_oe)
		else $error("pin driven in clear mode");
	a_clear_all_set: assert property (|channel_clear |-> &channel_clear)
		else $error("partial clear");
	a_codes_have_cause: assert property ($changed(active_codes) |-> quiet_q < 3'h7)
		else $error("active codes moved without cause");
endmodule : duc_update_ctrl_asserts

/* tb/duc_pin_host.sv */
`timescale 1ns/10ps
module duc_pin_host (
	input  wire logic pclk,
	input  wire logic pull_low,
	input  wire logic strobe,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_level,
	output logic      strobe_n
);
	// open-drain wire with pull-up, so a released pin reads high
	assign pin_level = !((pin_oe && !pin_out) || pull_low);
	assign strobe_n  = !strobe;
endmodule : duc_pin_host

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic         pclk     = 1'b0;
	logic         presetn  = 1'b0;
	logic         psel     = 1'b0;
	logic         penable  = 1'b0;
	logic         pwrite   = 1'b0;
	logic         strobe   = 1'b0;
	logic         pull_low = 1'b0;
	logic [7:0]   paddr    = 8'h00;
	logic [31:0]  pwdata   = 32'h0;
	logic [31:0]  prdata, rd;
	logic         pready, pslverr, pin_level, strobe_n, mf_out, mf_oe, err;
	logic [15:0]  chan_clear;
	logic [191:0] codes;
	int           failures  = 0;
	int           cmp_count = 0;
	always #2 pclk = ~pclk;
	duc_update_ctrl #(.CHANNELS(duc_pkg::CHANNELS), .CODE_W(duc_pkg::CODE_W)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.load_strobe_pin_n(strobe_n), .multi_function_pin_in(pin_level),
		.multi_function_pin_out(mf_out), .multi_function_pin_oe(mf_oe),
		.channel_clear(chan_clear), .active_codes(codes));
	duc_pin_host u_pin (.pclk(pclk), .pull_low(pull_low), .strobe(strobe), .pin_out(mf_out),
		.pin_oe(mf_oe), .pin_level(pin_level), .strobe_n(strobe_n));
	task give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n == 16)
		begin
			failures++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk
	// codes land a cycle after channel state, triggers one more
	task automatic act(input int ch, input logic [11:0] exp);
		repeat (3) @(posedge pclk);
		chk({20'h0, codes[ch*12 +: 12]}, {20'h0, exp});
	endtask : act
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(8'h28, 32'h0000_0000);
		rchk(8'h2C, 32'h0000_FFFF);
		$display("test reset values done");
		apb(1'b1, 8'h28, 32'h0000_0001);
		rchk(8'h28, 32'h0000_0001);
		apb(1'b1, 8'h2C, 32'h0000_FFFE);
		rchk(8'h2C, 32'h0000_FFFE);
		apb(1'b1, 8'h18, 32'h0000_ABC0);
		act(0, 12'h000);
		act(15, 12'hABC);
		apb(1'b1, 8'h38, 32'h0000_5A50);
		rchk(8'h38, 32'h0000_5A50);
		rchk(8'h18, 32'h0000_ABC0);
		$display("test broadcast done");
		apb(1'b1, 8'h2C, 32'h0000_FFFF);
		apb(1'b1, 8'h00, 32'h0000_1230);
		act(0, 12'h000);
		apb(1'b1, 8'h00, 32'h0001_4560);
		act(1, 12'h456);
		apb(1'b1, 8'h14, 32'h0000_0100);
		act(0, 12'h123);
		rchk(8'h14, 32'h0000_0000);
		apb(1'b1, 8'h00, 32'h0000_3210);
		strobe <= 1'b1;
		repeat (2) @(posedge pclk);
		strobe <= 1'b0;
		act(0, 12'h321);
		apb(1'b1, 8'h28, 32'h0000_0000);
		act(0, 12'h321);
		apb(1'b1, 8'h00, 32'h0000_7770);
		act(0, 12'h777);
		rchk(8'h08, 32'h0000_7770);
		rchk(8'h00, 32'h0000_7770);
		$display("test sync modes done");
		apb(1'b1, 8'h04, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		chk({31'h0, pin_level}, 32'h0);
		apb(1'b1, 8'h04, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk({31'h0, pin_level}, 32'h1);
		apb(1'b1, 8'h24, 32'h0000_0001);
		pull_low <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({16'h0, chan_clear}, 32'h0000_FFFF);
		pull_low <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({16'h0, chan_clear}, 32'h0);
		$display("test pin modes done");
		rchk(8'h3C, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test refusal done");
		give_verdict();
	end
endmodule : tb_top
bind duc_update_ctrl duc_update_ctrl_asserts #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .load_strobe_pin_n(load_strobe_pin_n),
	.multi_function_pin_in(multi_function_pin_in), .multi_function_pin_out(multi_function_pin_out),
	.multi_function_pin_oe(multi_function_pin_oe), .channel_clear(channel_clear),
	.active_codes(active_codes));
